// >>> rtl/hv_cfg_pkg.sv
// constants for the indirect high voltage configuration block
package hv_cfg_pkg;
  localparam int          CLK_HZ            = 25000000;
  localparam logic [7:0]  CFG_RESET         = 8'h00;
  localparam logic [7:0]  CMD_RD_CFG0       = 8'h00;
  localparam logic [7:0]  CMD_RD_CFG1       = 8'h01;
  localparam logic [7:0]  CMD_RD_STATUS     = 8'h02;
  localparam logic [7:0]  CMD_RD_MON        = 8'h03;
  localparam logic [7:0]  CMD_WR_CFG0       = 8'h08;
  localparam logic [7:0]  CMD_WR_CFG1       = 8'h09;
  localparam int          BIT_THERM_DIS     = 7;
  localparam int          BIT_OSC_EN        = 6;
  localparam int          BIT_BSD           = 5;
  localparam int          BIT_WAKE          = 4;
  localparam int          BIT_PSM           = 3;
  localparam int          BIT_LVF           = 2;
  localparam logic [1:0]  LIN_ON            = 2'h2;
  localparam int          BUSY_BIT          = 0;
  localparam int          RD_OK_BIT         = 1;
  localparam int          WR_OK_BIT         = 2;
  localparam int          IRQ_SRC_SUPPLY    = 16;
  // latency of the indirect path in ns (10 us)
  localparam int          LATENCY_NS        = 10000;
  localparam int          LATENCY_CYC       = (LATENCY_NS * (CLK_HZ / 1000000)) / 1000;
  localparam logic [8:0]  LATENCY_CNT       = 9'(LATENCY_CYC);
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_DONE = 3'h4
  } cmd_state_e;
endpackage : hv_cfg_pkg

// >>> rtl/hv_sync2.sv
// two flop synchroniser for pin level inputs
`timescale 1ns/1ns
module hv_sync2
(
  input  wire logic sys_clk_in,
  input  wire logic srst_in,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_r;
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : hv_sync2

// >>> rtl/hv_config_register_zero.sv
// indirect high voltage configuration registers behind command and data registers
`timescale 1ns/1ns
module hv_config_register_zero
(
  input  wire logic                   sys_clk_in,
  input  wire logic                   srst_in,
  input  wire logic                   cmd_wr_in,
  input  wire logic [7:0]             cmd_wdata_in,
  output logic      [7:0]             cmd_rdata_out,
  input  wire logic                   data_wr_in,
  input  wire logic [11:0]            data_wdata_in,
  output logic      [11:0]            data_rdata_out,
  input  wire logic [7:0]             hv_monitor_status_in,
  input  wire logic                   supply_low_in,
  input  wire logic                   thermal_event_in,
  input  wire logic [31:0]            irq_enable_mask_in,
  output logic                        wake_thermal_shutdown_out,
  output logic                        precision_osc_en_out,
  output logic                        bit_serial_device_mode_out,
  output logic                        lin_pullup_en_out,
  output logic                        wake_pin_drive_high_out,
  output logic                        wake_pin_pulldown_out,
  output logic                        supply_monitor_en_out,
  output logic                        supply_irq_line_out,
  output logic                        low_voltage_flag_en_out,
  output logic                        lin_driver_en_out,
  output logic      [7:0]             hv_config_one_out
);
  import hv_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  hv_config_zero_r;
  logic [7:0]  hv_config_one_r;
  logic [11:0] hv_data_word_r;
  logic [7:0]  cmd_r;
  logic        rd_ok_r;
  logic        wr_ok_r;
  logic [8:0]  wait_cnt_r;
  cmd_state_e  state_r;
  logic        supply_low_s;
  logic        thermal_s;
  logic [7:0]  monitor_s;
  logic        cmd_known;
  logic        cmd_is_write;

  // pin level inputs from the analogue side are asynchronous
  hv_sync2 u_sync_supply
  (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .async_in   (supply_low_in),
    .sync_out   (supply_low_s)
  );

  hv_sync2 u_sync_therm
  (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .async_in   (thermal_event_in),
    .sync_out   (thermal_s)
  );

  // monitor levels come straight off the analogue die
  // two cycles of sync lag are hidden inside the command latency
  for (genvar g = 0; g < 8; g++)
  begin : g_mon_sync
    hv_sync2 u_sync_mon
    (
      .sys_clk_in (sys_clk_in),
      .srst_in    (srst_in),
      .async_in   (hv_monitor_status_in[g]),
      .sync_out   (monitor_s[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    cmd_is_write = (cmd_r == CMD_WR_CFG0) || (cmd_r == CMD_WR_CFG1);
    cmd_known    = cmd_is_write || (cmd_r == CMD_RD_CFG0) || (cmd_r == CMD_RD_CFG1)
                   || (cmd_r == CMD_RD_STATUS) || (cmd_r == CMD_RD_MON);
  end

  // command sequencer models the slow indirect path
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      state_r    <= ST_IDLE;
      cmd_r      <= CMD_RD_CFG0;
      wait_cnt_r <= '0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          // commands while busy are ignored; software must poll first
          if (cmd_wr_in)
          begin
            cmd_r      <= cmd_wdata_in;
            wait_cnt_r <= LATENCY_CNT;
            state_r    <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (wait_cnt_r <= 9'h001)
            state_r <= ST_DONE;
          else
            wait_cnt_r <= wait_cnt_r - 9'h001;
        end
        ST_DONE:
          state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first config register, zero after reset
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      hv_config_zero_r <= CFG_RESET;
    // copy data byte in on completion; any value kept
    else if (state_r == ST_DONE && cmd_r == CMD_WR_CFG0)
      hv_config_zero_r <= hv_data_word_r[7:0];
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      hv_config_one_r <= CFG_RESET;
    else if (state_r == ST_DONE && cmd_r == CMD_WR_CFG1)
      hv_config_one_r <= hv_data_word_r[7:0];
  end

  // data register is the only read path for config zero; config one also drives hv_config_one_out
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      hv_data_word_r <= '0;
    else if (state_r == ST_DONE && !cmd_is_write && cmd_known)
    begin
      // read back selected register with its command tag
      hv_data_word_r[11:8] <= cmd_r[3:0];
      if (cmd_r == CMD_RD_CFG0)
        hv_data_word_r[7:0] <= hv_config_zero_r;
      else if (cmd_r == CMD_RD_CFG1)
        hv_data_word_r[7:0] <= hv_config_one_r;
      else if (cmd_r == CMD_RD_MON)
        hv_data_word_r[7:0] <= monitor_s;
      else
        hv_data_word_r[7:0] <= {7'h00, supply_low_s};
    end
    else if (data_wr_in && state_r == ST_IDLE)
      // upper tag bits are read only
      hv_data_word_r[7:0] <= data_wdata_in[7:0];
  end

  // completion status flags, valid only when not busy
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      rd_ok_r <= 1'b0;
    else if (state_r == ST_DONE)
      rd_ok_r <= cmd_known && !cmd_is_write;
  end

  // an unknown command leaves both flags low
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      wr_ok_r <= 1'b0;
    else if (state_r == ST_DONE)
      wr_ok_r <= cmd_is_write;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    cmd_rdata_out            = 8'h00;
    cmd_rdata_out[BUSY_BIT]  = (state_r != ST_IDLE);
    cmd_rdata_out[RD_OK_BIT] = rd_ok_r;
    cmd_rdata_out[WR_OK_BIT] = wr_ok_r;
    data_rdata_out           = hv_data_word_r;
    hv_config_one_out        = hv_config_one_r;
  end

  // control outputs to the analogue die
  // one flop each: a config write can never glitch a pin
  // shutdown only when enabled and thermal event seen
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      wake_thermal_shutdown_out <= 1'b0;
    else
      wake_thermal_shutdown_out <= !hv_config_zero_r[BIT_THERM_DIS] && thermal_s;
  end

  // oscillator power; start-up left to software
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      precision_osc_en_out <= 1'b0;
    else
      precision_osc_en_out <= hv_config_zero_r[BIT_OSC_EN];
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      bit_serial_device_mode_out <= 1'b0;
    else
      bit_serial_device_mode_out <= hv_config_zero_r[BIT_BSD];
  end

  // bit serial mode drops the pull-up
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      lin_pullup_en_out <= 1'b1;
    else
      lin_pullup_en_out <= !hv_config_zero_r[BIT_BSD];
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      wake_pin_drive_high_out <= 1'b0;
    else
      wake_pin_drive_high_out <= hv_config_zero_r[BIT_WAKE];
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      wake_pin_pulldown_out <= 1'b1;
    else
      wake_pin_pulldown_out <= !hv_config_zero_r[BIT_WAKE];
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      supply_monitor_en_out <= 1'b0;
    else
      supply_monitor_en_out <= hv_config_zero_r[BIT_PSM];
  end

  // irq needs monitor, mask bit and low supply
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      supply_irq_line_out <= 1'b0;
    else
      supply_irq_line_out <= hv_config_zero_r[BIT_PSM] && irq_enable_mask_in[IRQ_SRC_SUPPLY]
                             && supply_low_s;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      low_voltage_flag_en_out <= 1'b0;
    else
      low_voltage_flag_en_out <= hv_config_zero_r[BIT_LVF];
  end

  // only code 10 enables; reserved codes keep it off
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      lin_driver_en_out <= 1'b0;
    else
      lin_driver_en_out <= (hv_config_zero_r[1:0] == LIN_ON);
  end
endmodule : hv_config_register_zero

// >>> tb/hv_cfg_partner.sv
// far side model of the hv analogue circuits
`timescale 1ns/1ns
module hv_cfg_partner
(
  input  wire logic       low_req_in,
  input  wire logic       hot_req_in,
  input  wire logic       wake_high_in,
  input  wire logic       lvf_en_in,
  output logic            supply_low_out,
  output logic            thermal_event_out,
  output logic [7:0]      monitor_status_out
);
  assign supply_low_out = low_req_in;
  assign thermal_event_out = hot_req_in;
  // wake level, flag kept only while enabled
  assign monitor_status_out = {wake_high_in, 3'h0, lvf_en_in & low_req_in, 3'h0};
endmodule : hv_cfg_partner

// >>> tb/hv_cfg_assertions.sv
// port level checks of the hv config block
`timescale 1ns/1ns
module hv_cfg_assertions
(
  input wire logic        sys_clk_in,
  input wire logic        srst_in,
  input wire logic        cmd_wr_in,
  input wire logic [7:0]  cmd_rdata_out,
  input wire logic [11:0] data_rdata_out,
  input wire logic [31:0] irq_enable_mask_in,
  input wire logic        precision_osc_en_out,
  input wire logic        bit_serial_device_mode_out,
  input wire logic        lin_pullup_en_out,
  input wire logic        wake_pin_drive_high_out,
  input wire logic        wake_pin_pulldown_out,
  input wire logic        supply_monitor_en_out,
  input wire logic        supply_irq_line_out,
  input wire logic        lin_driver_en_out,
  input wire logic [7:0]  hv_config_one_out
);
  localparam int BUSY_HI = 251;
  logic [8:0] cnt_r;
  logic       busy_q_r;
  logic       done_r;
  logic       rst_q_r;
  wire        busy = cmd_rdata_out[0];
  ////////////////////////////////////////
  // rst_q_r masks the edge after reset, where old values still show
  always_ff @(posedge sys_clk_in)
  begin
    cnt_r    <= (srst_in || !busy) ? 9'h000 : cnt_r + 9'h001;
    busy_q_r <= busy && !srst_in;
    done_r   <= busy_q_r && !busy;
    rst_q_r  <= srst_in;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in || rst_q_r);
  sequence s_done;
    $fell(busy);
  endsequence
  ////////////////////////////////////////
  a_busy_from_cmd: assert property ($rose(busy) |-> $past(cmd_wr_in))
    else $error("busy without command");
  a_busy_length: assert property (s_done |-> cnt_r == BUSY_HI)
    else $error("busy length wrong");
  a_busy_bound: assert property (cnt_r <= BUSY_HI)
    else $error("busy too long");
  a_data_held: assert property (busy && $past(busy) |-> $stable(data_rdata_out))
    else $error("data moved while busy");
  a_cfg1_at_done: assert property ($changed(hv_config_one_out) |-> s_done)
    else $error("second config moved off completion");
  a_ctl_at_done: assert property ($changed({precision_osc_en_out, bit_serial_device_mode_out,
    supply_monitor_en_out, lin_driver_en_out, wake_pin_drive_high_out}) |-> done_r)
    else $error("control moved off completion");
  a_pullup_pair: assert property (lin_pullup_en_out != bit_serial_device_mode_out)
    else $error("pullup and bit serial clash");
  a_wake_pair: assert property (wake_pin_pulldown_out != wake_pin_drive_high_out)
    else $error("wake drive and pulldown clash");
  a_irq_gate: assert property (supply_irq_line_out |->
    supply_monitor_en_out && $past(irq_enable_mask_in[16]))
    else $error("supply irq not gated");
endmodule : hv_cfg_assertions
bind hv_config_register_zero hv_cfg_assertions u_chk
(
  .sys_clk_in, .srst_in, .cmd_wr_in, .cmd_rdata_out, .data_rdata_out, .irq_enable_mask_in,
  .precision_osc_en_out, .bit_serial_device_mode_out, .lin_pullup_en_out, .wake_pin_drive_high_out,
  .wake_pin_pulldown_out, .supply_monitor_en_out, .supply_irq_line_out, .lin_driver_en_out, .hv_config_one_out
);

// >>> tb/test_hv_config_register_zero.sv
// self-checking bench for the indirect hv config block
`timescale 1ns/1ns
module test_hv_config_register_zero;
  import hv_cfg_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        cmd_wr_in = 1'b0;
  logic        data_wr_in = 1'b0;
  logic        low_req = 1'b1;
  logic        hot_req = 1'b1;
  logic [7:0]  cmd_wdata_in = 8'h00;
  logic [11:0] data_wdata_in = 12'h000;
  logic [31:0] irq_enable_mask_in = 32'h0;
  logic [7:0]  vals [4] = '{8'h56, 8'hA9, 8'h3F, 8'hC0};
  int          err_count = 0;
  int          checks_done = 0;
  wire  [7:0]  cmd_rdata_out, hv_config_one_out, hv_monitor_status_in;
  wire  [11:0] data_rdata_out;
  wire         supply_low_in, thermal_event_in, wake_thermal_shutdown_out, precision_osc_en_out;
  wire         bit_serial_device_mode_out, lin_pullup_en_out, wake_pin_drive_high_out, wake_pin_pulldown_out;
  wire         supply_monitor_en_out, supply_irq_line_out, low_voltage_flag_en_out, lin_driver_en_out;
  wire  [9:0]  ctl = {wake_thermal_shutdown_out, precision_osc_en_out, bit_serial_device_mode_out,
    lin_pullup_en_out, wake_pin_drive_high_out, wake_pin_pulldown_out, supply_monitor_en_out,
    supply_irq_line_out, low_voltage_flag_en_out, lin_driver_en_out};
  hv_config_register_zero u_dut
  (
    .sys_clk_in, .srst_in, .cmd_wr_in, .cmd_wdata_in, .cmd_rdata_out, .data_wr_in, .data_wdata_in,
    .data_rdata_out, .hv_monitor_status_in, .supply_low_in, .thermal_event_in, .irq_enable_mask_in,
    .wake_thermal_shutdown_out, .precision_osc_en_out, .bit_serial_device_mode_out, .lin_pullup_en_out,
    .wake_pin_drive_high_out, .wake_pin_pulldown_out, .supply_monitor_en_out, .supply_irq_line_out,
    .low_voltage_flag_en_out, .lin_driver_en_out, .hv_config_one_out
  );
  hv_cfg_partner u_far
  (
    .low_req_in(low_req), .hot_req_in(hot_req), .wake_high_in(wake_pin_drive_high_out),
    .lvf_en_in(low_voltage_flag_en_out), .supply_low_out(supply_low_in), .thermal_event_out(thermal_event_in),
    .monitor_status_out(hv_monitor_status_in)
  );
  always #20 sys_clk_in = ~sys_clk_in;
  ////////////////////////////////////////
  task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // bad retries a data and command write while busy
  task automatic cmd(logic [7:0] c, logic [7:0] st, logic bad);
    int n = 0;
    cmd_wr_in = 1'b1;
    cmd_wdata_in = c;
    @(negedge sys_clk_in);
    cmd_wr_in = bad;
    cmd_wdata_in = CMD_WR_CFG1;
    data_wr_in = bad;
    data_wdata_in = 12'h0FF;
    @(negedge sys_clk_in);
    cmd_wr_in = 1'b0;
    data_wr_in = 1'b0;
    while (cmd_rdata_out[0] !== 1'b0 && n++ < 400)
      @(negedge sys_clk_in);
    chk("status", {4'h0, st}, {4'h0, cmd_rdata_out});
  endtask : cmd
  task automatic wr(logic n, logic [7:0] d, logic bad);
    data_wr_in = 1'b1;
    data_wdata_in = {4'h0, d};
    @(negedge sys_clk_in);
    data_wr_in = 1'b0;
    cmd(n ? CMD_WR_CFG1 : CMD_WR_CFG0, 8'h04, bad);
  endtask : wr
  task automatic rd(logic [7:0] c, logic [7:0] d);
    cmd(c, 8'h02, 1'b0);
    chk("data", {c[3:0], d}, data_rdata_out);
  endtask : rd
  function automatic logic [9:0] exp_ctl(logic [7:0] v, logic m);
    return {~v[7] & hot_req, v[6], v[5], ~v[5], v[4], ~v[4], v[3], v[3] & m & low_req, v[2], v[1:0] == 2'h2};
  endfunction : exp_ctl
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    err_count++;
    end_of_test();
  end
  initial
  begin
    repeat (2) @(negedge sys_clk_in);
    srst_in = 1'b0;
    rd(CMD_RD_CFG0, 8'h00);
    rd(CMD_RD_CFG1, 8'h00);
    chk("ctl", {2'h0, exp_ctl(8'h00, 1'b0)}, {2'h0, ctl});
    foreach (vals[i])
    begin
      irq_enable_mask_in = {15'h0, i[0], 16'h0};
      hot_req = i[1];
      wr(1'b0, vals[i], 1'b0);
      @(negedge sys_clk_in);
      chk("ctl", {2'h0, exp_ctl(vals[i], i[0])}, {2'h0, ctl});
      rd(CMD_RD_CFG0, vals[i]);
      if (vals[i][BIT_OSC_EN])
      begin
        repeat (1750) @(negedge sys_clk_in);
        chk("osc", 12'h001, {11'h000, precision_osc_en_out});
      end
    end
    wr(1'b0, 8'h14, 1'b0);
    rd(CMD_RD_MON, 8'h88);
    rd(CMD_RD_STATUS, 8'h01);
    wr(1'b1, 8'hA5, 1'b0);
    chk("cfg1", 12'h0A5, {4'h0, hv_config_one_out});
    rd(CMD_RD_CFG0, 8'h14);
    wr(1'b0, 8'h3C, 1'b1);
    rd(CMD_RD_CFG0, 8'h3C);
    rd(CMD_RD_CFG1, 8'hA5);
    cmd(8'h05, 8'h00, 1'b0);
    chk("data", 12'h1A5, data_rdata_out);
    end_of_test();
  end
endmodule : test_hv_config_register_zero
